// >>> verilog/tcs_defs.svh
// Notes on behaviour
// [R1] Limit-C match drives line B per field
// [R2] External event drives line B per field
// [R3] Software trigger drives line B per field
// [R4] Counter value read-only, low 16 bits
// [R5] A/B writable only in waveform mode
// [R6] Limit C readable and writable always
// [R7] Overflow flag sticky, cleared by status read
// [R8] Capture overrun flag, zero in waveform
// [R9] Match A/B flags, waveform mode only
// [R10] Limit-C match flag in both modes
// [R11] Capture A/B flags, capture mode only
// [R12] External trigger flag, cleared by read
// [R13] Bit 16 shows counter clock enabled
// [R14] Bit 17 mirrors line A level
// [R15] Bit 18 mirrors line B level
// [R16] Enable command sets interrupt enables
// [R17] Disable command clears interrupt enables
// [R18] Mask view shows enabled interrupts
// [R19] Mode bit: 0 capture, 1 waveform
// [R20] Interrupt while enabled flag set
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH
// ****************************************
// Register offsets
// ****************************************
`define TCS_OFS_CTRL 8'h00
`define TCS_OFS_MODE 8'h04
`define TCS_OFS_CNT 8'h10
`define TCS_OFS_CCA 8'h14
`define TCS_OFS_CCB 8'h18
`define TCS_OFS_LIM 8'h1C
`define TCS_OFS_STAT 8'h20
`define TCS_OFS_IEN 8'h24
`define TCS_OFS_IDIS 8'h28
`define TCS_OFS_IMASK 8'h2C
// ****************************************
// Field positions and reset values
// ****************************************
`define TCS_CTRL_CLKEN 0
`define TCS_CTRL_CLKDIS 1
`define TCS_CTRL_SWTRG 2
`define TCS_MODE_W 9
`define TCS_NFLAG 8
`define TCS_F_OVF 0
`define TCS_F_OVR 1
`define TCS_F_MA 2
`define TCS_F_MB 3
`define TCS_F_MC 4
`define TCS_F_CA 5
`define TCS_F_CB 6
`define TCS_F_ET 7
`define TCS_RST_MODE 9'h000
`define TCS_RST_FLAGS 8'h00
`define TCS_RST_CNT 16'h0000
// Flags that each mode may show in the status word
`define TCS_VIS_WAVE 8'h9D
`define TCS_VIS_CAP 8'hF3
`endif

// >>> verilog/tcs_pkg.sv
`default_nettype none
package tcs_pkg;
  // Codes follow declaration order: 00 none, 01 set, 10 clear, 11 toggle
  typedef enum logic [1:0] {ACT_NONE, ACT_SET, ACT_CLEAR, ACT_TOGGLE} tcs_act_e;
  typedef struct packed {
    tcs_act_e soft_act;
    tcs_act_e ext_act;
    tcs_act_e lim_act;
    logic [1:0] ext_edge;
    logic wave;
  } tcs_mode_s;
endpackage : tcs_pkg
`default_nettype wire

// >>> verilog/tcs_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcs_defs.svh"
module tcs_top #(
  parameter int CW = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rd_data,
  input wire logic ext_event_in,
  input wire logic io_line_a_in,
  output logic io_line_a_out,
  output logic io_line_a_oe,
  input wire logic io_line_b_in,
  output logic io_line_b_out,
  output logic io_line_b_oe,
  output logic irq
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic act_apply(tcs_pkg::tcs_act_e a, logic hit, logic cur);
    logic r;
    r = cur;
    if (hit) begin
      unique case (a)
        tcs_pkg::ACT_NONE: r = cur;
        tcs_pkg::ACT_SET: r = 1'b1;
        tcs_pkg::ACT_CLEAR: r = 1'b0;
        tcs_pkg::ACT_TOGGLE: r = ~cur;
      endcase
    end
    return r;
  endfunction : act_apply

  // Selector bit 0 rising, bit 1 falling, both for each edge
  function automatic logic edge_hit(logic [1:0] sel, logic prev, logic now);
    return (sel[0] & ~prev & now) | (sel[1] & prev & ~now);
  endfunction : edge_hit

  // ****************************************
  // State
  // ****************************************
  tcs_pkg::tcs_mode_s mode_r;
  logic [CW-1:0] cnt_r, cca_r, ccb_r, lim_r;
  logic clk_on_r;
  logic [`TCS_NFLAG-1:0] flags_r, imask_r;
  logic a_unread_r, b_unread_r;
  logic ext_prev_r, a_in_r, b_in_r;
  logic line_a_r, line_b_r;
  logic [31:0] rd_data_r;
  logic irq_r;

  // ****************************************
  // Decode
  // ****************************************
  wire logic wave = mode_r.wave; // see [R19]
  wire logic wr_ctrl = wr_stb && addr == `TCS_OFS_CTRL;
  wire logic wr_mode = wr_stb && addr == `TCS_OFS_MODE;
  wire logic wr_cca = wr_stb && addr == `TCS_OFS_CCA && wave; // see [R5]
  wire logic wr_ccb = wr_stb && addr == `TCS_OFS_CCB && wave; // see [R5]
  wire logic wr_lim = wr_stb && addr == `TCS_OFS_LIM; // see [R6]
  wire logic wr_ien = wr_stb && addr == `TCS_OFS_IEN;
  wire logic wr_idis = wr_stb && addr == `TCS_OFS_IDIS;
  wire logic rd_stat = rd_stb && addr == `TCS_OFS_STAT;
  wire logic rd_cca = rd_stb && addr == `TCS_OFS_CCA;
  wire logic rd_ccb = rd_stb && addr == `TCS_OFS_CCB;

  wire logic sw_trg = wr_ctrl && wr_data[`TCS_CTRL_SWTRG];
  wire logic ext_trg = edge_hit(mode_r.ext_edge, ext_prev_r, ext_event_in);
  wire logic restart = sw_trg || ext_trg;
  wire logic cnt_max = cnt_r == {CW{1'b1}};
  wire logic ovf = clk_on_r && cnt_max && !restart;
  wire logic m_a = wave && clk_on_r && cnt_r == cca_r;
  wire logic m_b = wave && clk_on_r && cnt_r == ccb_r;
  wire logic m_c = clk_on_r && cnt_r == lim_r;
  // Line A edges load A on rise, B on fall, capture mode only
  wire logic ld_a = !wave && !a_in_r && io_line_a_in;
  wire logic ld_b = !wave && a_in_r && !io_line_a_in;
  wire logic ovr = (ld_a && a_unread_r) || (ld_b && b_unread_r);

  wire logic [`TCS_NFLAG-1:0] ev;
  assign ev[`TCS_F_OVF] = ovf; // see [R7]
  assign ev[`TCS_F_OVR] = ovr; // see [R8]
  assign ev[`TCS_F_MA] = m_a; // see [R9]
  assign ev[`TCS_F_MB] = m_b; // see [R9]
  assign ev[`TCS_F_MC] = m_c; // see [R10]
  assign ev[`TCS_F_CA] = ld_a; // see [R11]
  assign ev[`TCS_F_CB] = ld_b; // see [R11]
  assign ev[`TCS_F_ET] = ext_trg; // see [R12]

  // Stale flags of the other mode are hidden, kept until a status read clears them
  wire logic [`TCS_NFLAG-1:0] mode_mask = wave ? `TCS_VIS_WAVE : `TCS_VIS_CAP;
  wire logic [`TCS_NFLAG-1:0] flags_view = flags_r & mode_mask;
  // Set wins over the read clear
  wire logic [`TCS_NFLAG-1:0] flags_nxt = ev | (rd_stat ? `TCS_RST_FLAGS : flags_r);
  wire logic [`TCS_NFLAG-1:0] imask_nxt = wr_ien ? (imask_r | wr_data[7:0]) // see [R16]
                                        : wr_idis ? (imask_r & ~wr_data[7:0]) // see [R17]
                                        : imask_r;

  wire logic mirror_a = wave ? line_a_r : a_in_r; // see [R14]
  wire logic mirror_b = wave ? line_b_r : b_in_r; // see [R15]
  wire logic [31:0] stat_word = {13'h0000, mirror_b, mirror_a, clk_on_r, 8'h00, // see [R13]
                                 flags_view};

  // Priority soft trigger over external event over limit match
  wire logic lb_c = act_apply(mode_r.lim_act, m_c, line_b_r); // see [R1]
  wire logic lb_e = act_apply(mode_r.ext_act, ext_trg, lb_c); // see [R2]
  wire logic lb_nxt = act_apply(mode_r.soft_act, sw_trg, lb_e); // see [R3]
  wire logic la_nxt = m_c ? 1'b0 : (m_a ? 1'b1 : line_a_r);

  wire logic clk_on_nxt = (wr_ctrl && wr_data[`TCS_CTRL_CLKDIS]) ? 1'b0
                        : (restart || (wr_ctrl && wr_data[`TCS_CTRL_CLKEN])) ? 1'b1
                        : clk_on_r;
  wire logic [CW-1:0] cnt_nxt = restart ? `TCS_RST_CNT
                              : clk_on_r ? cnt_r + 1'b1 : cnt_r;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (rd_stb) begin
      case (addr)
        `TCS_OFS_MODE: rd_mux = {{(32-`TCS_MODE_W){1'b0}}, mode_r};
        `TCS_OFS_CNT: rd_mux = {{(32-CW){1'b0}}, cnt_r}; // see [R4]
        `TCS_OFS_CCA: rd_mux = {{(32-CW){1'b0}}, cca_r};
        `TCS_OFS_CCB: rd_mux = {{(32-CW){1'b0}}, ccb_r};
        `TCS_OFS_LIM: rd_mux = {{(32-CW){1'b0}}, lim_r}; // see [R6]
        `TCS_OFS_STAT: rd_mux = stat_word;
        `TCS_OFS_IMASK: rd_mux = {24'h000000, imask_r}; // see [R18]
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r <= tcs_pkg::tcs_mode_s'(`TCS_RST_MODE);
      cnt_r <= `TCS_RST_CNT;
      cca_r <= `TCS_RST_CNT;
      ccb_r <= `TCS_RST_CNT;
      lim_r <= `TCS_RST_CNT;
      clk_on_r <= 1'b0;
    end else begin
      if (wr_mode) mode_r <= tcs_pkg::tcs_mode_s'(wr_data[`TCS_MODE_W-1:0]);
      cnt_r <= cnt_nxt;
      if (wr_cca) cca_r <= wr_data[CW-1:0];
      else if (ld_a) cca_r <= cnt_r;
      if (wr_ccb) ccb_r <= wr_data[CW-1:0];
      else if (ld_b) ccb_r <= cnt_r;
      if (wr_lim) lim_r <= wr_data[CW-1:0];
      clk_on_r <= clk_on_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_r <= `TCS_RST_FLAGS;
      imask_r <= `TCS_RST_FLAGS;
      a_unread_r <= 1'b0;
      b_unread_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt; // see [R7] [R10] [R12]
      imask_r <= imask_nxt;
      a_unread_r <= ld_a || (a_unread_r && !rd_cca); // see [R8]
      b_unread_r <= ld_b || (b_unread_r && !rd_ccb); // see [R8]
      irq_r <= |(flags_view & imask_r); // see [R20]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_prev_r <= 1'b0;
      a_in_r <= 1'b0;
      b_in_r <= 1'b0;
      line_a_r <= 1'b0;
      line_b_r <= 1'b0;
      io_line_a_oe <= 1'b0;
      io_line_b_oe <= 1'b0;
      rd_data_r <= 32'h0000_0000;
    end else begin
      ext_prev_r <= ext_event_in;
      a_in_r <= io_line_a_in;
      b_in_r <= io_line_b_in;
      line_a_r <= la_nxt;
      line_b_r <= lb_nxt;
      io_line_a_oe <= mode_r.wave;
      io_line_b_oe <= mode_r.wave;
      rd_data_r <= rd_mux;
    end
  end

  assign rd_data = rd_data_r;
  assign irq = irq_r;
  assign io_line_a_out = line_a_r;
  assign io_line_b_out = line_b_r;

  // ****************************************
  // Checks
  // ****************************************
  // Low byte of the write data one cycle back, taken every cycle, for the command checks
  logic [7:0] wr_data_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) wr_data_q <= 8'h00;
    else wr_data_q <= wr_data[7:0];
  end

  a_ovf_flag_set: assert property (@(posedge clk) disable iff (rst) // see [R7]
    ovf |=> flags_r[`TCS_F_OVF])
    else $error("overflow did not set its flag");

  a_stat_rd_clear: assert property (@(posedge clk) disable iff (rst) // see [R10]
    (rd_stat && !m_c) |=> !flags_r[`TCS_F_MC])
    else $error("status read left limit flag set");

  a_cap_wave_zero: assert property (@(posedge clk) disable iff (rst) // see [R11]
    wave |-> (flags_view[`TCS_F_CA] == 1'b0 && flags_view[`TCS_F_OVR] == 1'b0))
    else $error("capture flags visible in waveform mode");

  a_match_a_view: assert property (@(posedge clk) disable iff (rst) // see [R9]
    (!wave && !$past(wave)) |-> !flags_view[`TCS_F_MA] && !flags_view[`TCS_F_MB])
    else $error("match flags visible in capture mode");

  a_cca_write_lock: assert property (@(posedge clk) disable iff (rst) // see [R5]
    (wr_stb && addr == `TCS_OFS_CCA && !wave && !ld_a) |=> $stable(cca_r))
    else $error("register A written in capture mode");

  a_ien_sets: assert property (@(posedge clk) disable iff (rst) // see [R16]
    wr_ien |=> ((imask_r & wr_data_q) == wr_data_q))
    else $error("enable command did not take");

  a_idis_clears: assert property (@(posedge clk) disable iff (rst) // see [R17]
    wr_idis |=> ((imask_r & wr_data_q) == 8'h00))
    else $error("disable command did not take");

  a_irq_follows: assert property (@(posedge clk) disable iff (rst) // see [R20]
    ##1 irq == |($past(flags_r & mode_mask) & $past(imask_r)))
    else $error("interrupt does not follow enabled flags");

  a_cnt_read_live: assert property (@(posedge clk) disable iff (rst) // see [R4]
    (rd_stb && addr == `TCS_OFS_CNT) |=> rd_data == {16'h0000, $past(cnt_r)})
    else $error("count read not live value");

  a_line_b_soft: assert property (@(posedge clk) disable iff (rst) // see [R3]
    (sw_trg && mode_r.soft_act == tcs_pkg::ACT_TOGGLE) |=> line_b_r != $past(line_b_r))
    else $error("soft trigger toggle missed");

  a_clk_status: assert property (@(posedge clk) disable iff (rst) // see [R13]
    (rd_stat) |=> rd_data[16] == $past(clk_on_r))
    else $error("clock status bit wrong");

  // ****************************************
  // Checks on flags and registers
  // ****************************************
  a_ovr_flag_set: assert property (@(posedge clk) disable iff (rst) // see [R8]
    ovr |=> flags_r[`TCS_F_OVR])
    else $error("overrun did not set its flag");

  a_ma_flag_set: assert property (@(posedge clk) disable iff (rst) // see [R9]
    m_a |=> flags_r[`TCS_F_MA])
    else $error("match A did not set its flag");

  a_mb_flag_set: assert property (@(posedge clk) disable iff (rst) // see [R9]
    m_b |=> flags_r[`TCS_F_MB])
    else $error("match B did not set its flag");

  a_mc_flag_set: assert property (@(posedge clk) disable iff (rst) // see [R10]
    m_c |=> flags_r[`TCS_F_MC])
    else $error("limit match did not set its flag");

  a_ca_flag_set: assert property (@(posedge clk) disable iff (rst) // see [R11]
    ld_a |=> flags_r[`TCS_F_CA])
    else $error("capture A did not set its flag");

  a_cb_flag_set: assert property (@(posedge clk) disable iff (rst) // see [R11]
    ld_b |=> flags_r[`TCS_F_CB])
    else $error("capture B did not set its flag");

  a_et_flag_set: assert property (@(posedge clk) disable iff (rst) // see [R12]
    ext_trg |=> flags_r[`TCS_F_ET])
    else $error("external trigger did not set its flag");

  a_ovf_rd_clear: assert property (@(posedge clk) disable iff (rst) // see [R7]
    (rd_stat && !ovf) |=> !flags_r[`TCS_F_OVF])
    else $error("status read left overflow flag set");

  a_et_rd_clear: assert property (@(posedge clk) disable iff (rst) // see [R12]
    (rd_stat && !ext_trg) |=> !flags_r[`TCS_F_ET])
    else $error("status read left trigger flag set");

  // Without a status read no flag may drop on its own
  a_flag_sticky: assert property (@(posedge clk) disable iff (rst) // see [R7]
    !rd_stat |=> ((flags_r & $past(flags_r)) == $past(flags_r)))
    else $error("flag dropped without status read");

  a_ccb_write_lock: assert property (@(posedge clk) disable iff (rst) // see [R5]
    (wr_stb && addr == `TCS_OFS_CCB && !wave && !ld_b) |=> $stable(ccb_r))
    else $error("register B written in capture mode");

  a_cca_write_take: assert property (@(posedge clk) disable iff (rst) // see [R5]
    (wr_stb && addr == `TCS_OFS_CCA && wave) |=> cca_r == $past(wr_data[CW-1:0]))
    else $error("register A write lost in waveform mode");

  a_lim_write_take: assert property (@(posedge clk) disable iff (rst) // see [R6]
    wr_lim |=> lim_r == $past(wr_data[CW-1:0]))
    else $error("limit write lost");

  a_lim_read: assert property (@(posedge clk) disable iff (rst) // see [R6]
    (rd_stb && addr == `TCS_OFS_LIM) |=> rd_data == {16'h0000, $past(lim_r)})
    else $error("limit read wrong");

  a_mask_read: assert property (@(posedge clk) disable iff (rst) // see [R18]
    (rd_stb && addr == `TCS_OFS_IMASK) |=> rd_data == {24'h000000, $past(imask_r)})
    else $error("mask view read wrong");

  a_cnt_upper_zero: assert property (@(posedge clk) disable iff (rst) // see [R4]
    (rd_stb && addr == `TCS_OFS_CNT) |=> rd_data[31:16] == 16'h0000)
    else $error("count upper bits not zero");

  a_stat_mirror_a: assert property (@(posedge clk) disable iff (rst) // see [R14]
    rd_stat |=> rd_data[17] == $past(mirror_a))
    else $error("line A mirror bit wrong");

  a_stat_mirror_b: assert property (@(posedge clk) disable iff (rst) // see [R15]
    rd_stat |=> rd_data[18] == $past(mirror_b))
    else $error("line B mirror bit wrong");

  a_cap_a_value: assert property (@(posedge clk) disable iff (rst) // see [R11]
    ld_a |=> cca_r == $past(cnt_r))
    else $error("capture A did not load the count");

  a_cap_b_value: assert property (@(posedge clk) disable iff (rst) // see [R11]
    ld_b |=> ccb_r == $past(cnt_r))
    else $error("capture B did not load the count");

  // ****************************************
  // Checks on lines and clock
  // ****************************************
  // Higher-priority sources are excluded so each action is seen alone
  a_lb_limit_set: assert property (@(posedge clk) disable iff (rst) // see [R1]
    (m_c && !ext_trg && !sw_trg && mode_r.lim_act == tcs_pkg::ACT_SET) |=> line_b_r)
    else $error("limit match did not set line B");

  a_lb_limit_clr: assert property (@(posedge clk) disable iff (rst) // see [R1]
    (m_c && !ext_trg && !sw_trg && mode_r.lim_act == tcs_pkg::ACT_CLEAR) |=> !line_b_r)
    else $error("limit match did not clear line B");

  a_lb_ext_set: assert property (@(posedge clk) disable iff (rst) // see [R2]
    (ext_trg && !sw_trg && mode_r.ext_act == tcs_pkg::ACT_SET) |=> line_b_r)
    else $error("external event did not set line B");

  a_lb_soft_clr: assert property (@(posedge clk) disable iff (rst) // see [R3]
    (sw_trg && mode_r.soft_act == tcs_pkg::ACT_CLEAR) |=> !line_b_r)
    else $error("soft trigger did not clear line B");

  a_lb_idle_hold: assert property (@(posedge clk) disable iff (rst) // see [R1]
    (!m_c && !ext_trg && !sw_trg) |=> $stable(line_b_r))
    else $error("line B moved without a cause");

  a_lb_drive_mode: assert property (@(posedge clk) disable iff (rst) // see [R19]
    ##1 io_line_b_oe == $past(mode_r.wave))
    else $error("line B drive does not follow mode");

  a_clk_dis_wins: assert property (@(posedge clk) disable iff (rst) // see [R13]
    (wr_ctrl && wr_data[`TCS_CTRL_CLKDIS]) |=> !clk_on_r)
    else $error("clock disable did not stop the count");
endmodule : tcs_top
`default_nettype wire

// >>> tb/tcs_pins.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Far-side pin model
// ****************************************
module tcs_pins (
  input wire logic a_oe,
  input wire logic a_out,
  input wire logic b_oe,
  input wire logic b_out,
  output logic a_in,
  output logic b_in,
  output logic ev
);
  logic a_lvl = 1'b0;
  logic b_lvl = 1'b1;
  initial ev = 1'b0;
  // Wire follows the channel while it drives, else the outside level
  assign a_in = a_oe ? a_out : a_lvl;
  assign b_in = b_oe ? b_out : b_lvl;
endmodule : tcs_pins
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcs_defs.svh"
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rd_data;
  logic a_in, a_out, a_oe, b_in, b_out, b_oe, ev, irq;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  logic exp_b;
  logic [31:0] d;
  tcs_top dut (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .ext_event_in(ev), .io_line_a_in(a_in),
    .io_line_a_out(a_out), .io_line_a_oe(a_oe), .io_line_b_in(b_in),
    .io_line_b_out(b_out), .io_line_b_oe(b_oe), .irq(irq));
  tcs_pins pins (.a_oe(a_oe), .a_out(a_out), .b_oe(b_oe), .b_out(b_out), .a_in(a_in),
    .b_in(b_in), .ev(ev));
  always #12.5 clk = ~clk;
  // ****************************************
  // Bus and check helpers
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wr_data <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    // Data stand one cycle only; taken mid-cycle, clear of the edge
    @(negedge clk);
    v = rd_data;
  endtask : rd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      summarize();
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  // Kind 0 limit match, 1 external event, 2 software trigger
  task automatic line_b_act(input int k, input logic [1:0] c);
    wr(`TCS_OFS_MODE, {23'h0, (k == 2) ? c : 2'h0, (k == 1) ? c : 2'h0,
      (k == 0) ? c : 2'h0, 2'h1, 1'b1});
    if (k == 1) begin
      pins.ev <= 1'b1;
      @(posedge clk);
      pins.ev <= 1'b0;
    end else wr(`TCS_OFS_CTRL, 32'h4);
    repeat (12) @(posedge clk);
    wr(`TCS_OFS_CTRL, 32'h2);
    exp_b = (c == 2'h1) ? 1'b1 : (c == 2'h2) ? 1'b0 : (c == 2'h3) ? ~exp_b : exp_b;
    chk({31'h0, b_out}, {31'h0, exp_b}, "line b");
    rd(`TCS_OFS_STAT, d);
    chk({31'h0, d[18]}, {31'h0, exp_b}, "line b mirror");
  endtask : line_b_act
  task automatic regs_test;
    rd(`TCS_OFS_STAT, d);
    // Partner holds line B high, so its mirror reads 1 in capture mode
    chk(d, 32'h0004_0000, "status after reset");
    wr(`TCS_OFS_CCA, 32'h00AB);
    rd(`TCS_OFS_CCA, d);
    chk(d, 32'h0, "A write in capture");
    wr(`TCS_OFS_LIM, 32'h0005);
    rd(`TCS_OFS_LIM, d);
    chk(d, 32'h5, "limit readback");
    rd(8'h3C, d);
    chk(d, 32'h0, "unmapped read");
    wr(`TCS_OFS_MODE, 32'h1);
    wr(`TCS_OFS_CCA, 32'h00AB);
    rd(`TCS_OFS_CCA, d);
    chk(d, 32'hAB, "A write in waveform");
  endtask : regs_test
  task automatic wave_test;
    logic [1:0] seq [5] = '{2'h1, 2'h3, 2'h2, 2'h3, 2'h0};
    exp_b = 1'b0;
    for (int k = 0; k < 3; k++) begin
      foreach (seq[i]) line_b_act(k, seq[i]);
    end
    rd(`TCS_OFS_STAT, d);
    chk(d[7:0], 32'h0, "flags cleared by read");
    line_b_act(1, 2'h0);
    chk({31'h0, d[7]}, 32'h1, "ext trigger flag");
  endtask : wave_test
  task automatic irq_test;
    wr(`TCS_OFS_IEN, 32'h10);
    rd(`TCS_OFS_IMASK, d);
    chk(d, 32'h10, "mask after enable");
    // A at 3 and B at 0 are both passed by the restarted count
    wr(`TCS_OFS_CCA, 32'h3);
    line_b_act(2, 2'h0);
    chk({31'h0, irq}, 32'h1, "irq raised");
    chk(d[7:0], 32'h1C, "limit, A and B match flags");
    @(negedge clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wr(`TCS_OFS_IDIS, 32'h10);
    rd(`TCS_OFS_IMASK, d);
    chk(d, 32'h0, "mask after disable");
  endtask : irq_test
  task automatic capture_test;
    wr(`TCS_OFS_MODE, 32'h0);
    wr(`TCS_OFS_CTRL, 32'h1);
    rd(`TCS_OFS_CNT, d);
    chk(d[31:16], 32'h0, "count upper bits");
    chk({31'h0, d[15:0] != 16'h0}, 32'h1, "count running");
    rd(`TCS_OFS_STAT, d);
    chk({31'h0, d[16]}, 32'h1, "clock on");
    @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      pins.a_lvl <= 1'b1;
      repeat (3) @(posedge clk);
      pins.a_lvl <= 1'b0;
      repeat (3) @(posedge clk);
    end
    pins.a_lvl <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`TCS_OFS_STAT, d);
    chk({29'h0, d[17], d[6:5]}, 32'h7, "capture flags and mirror");
    chk({31'h0, d[1]}, 32'h1, "overrun");
    chk({30'h0, d[3:2]}, 32'h0, "match flags hidden");
    repeat (65540) @(posedge clk);
    rd(`TCS_OFS_STAT, d);
    chk({31'h0, d[0]}, 32'h1, "overflow");
    rd(`TCS_OFS_STAT, d);
    chk({31'h0, d[0]}, 32'h0, "overflow cleared");
  endtask : capture_test
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    regs_test();
    wave_test();
    irq_test();
    capture_test();
    summarize();
  end
endmodule : tb
`default_nettype wire
